// ---- move_or_rotate_pkg.sv ----
// Constants, types and decoding shared by the instruction slice
package move_or_rotate_pkg;
	localparam int DATA_W    = 4;
	localparam int RAM_AW    = 7;
	localparam int RAM_DEPTH = 128;
	localparam int WR_AW     = 4;
	localparam int ROM_AW    = 8;
	localparam int ROM_DEPTH = 256;
	localparam int INSTR_W   = 16;
	localparam int APB_AW    = 8;
	localparam int APB_DW    = 32;

	localparam logic [4:0]  OPC_MOVE_TO_MEM  = 5'h0F;
	localparam logic [4:0]  OPC_MOVE_TO_WR   = 5'h0D;
	localparam logic [8:0]  OPC_PTR_LOW      = 9'h130;
	localparam logic [8:0]  OPC_PTR_HIGH     = 9'h131;
	localparam logic [8:0]  OPC_TABLE_READ   = 9'h132;
	localparam logic [8:0]  OPC_OR_MEM       = 9'h074;
	localparam logic [8:0]  OPC_OR_MEM_WB    = 9'h076;
	localparam logic [7:0]  OPC_OR_IMM       = 8'h3E;
	localparam logic [7:0]  OPC_OR_IMM_WB    = 8'h3F;
	localparam logic [8:0]  OPC_ROTATE       = 9'h14C;
	localparam logic [15:0] OPC_NO_OPERATION = 16'h0000;

	localparam logic [APB_AW-1:0] REG_CTRL      = 8'h00;
	localparam logic [APB_AW-1:0] REG_STATUS    = 8'h04;
	localparam logic [APB_AW-1:0] REG_CORE      = 8'h08;
	localparam logic [APB_AW-1:0] REG_TABLE_PTR = 8'h0C;
	localparam logic [APB_AW-1:0] REG_ROM_ADDR  = 8'h10;
	localparam logic [APB_AW-1:0] REG_ROM_DATA  = 8'h14;
	localparam logic [APB_AW-1:0] REG_RAM_ADDR  = 8'h18;
	localparam logic [APB_AW-1:0] REG_RAM_DATA  = 8'h1C;

	localparam int CTRL_RUN_BIT   = 0;
	localparam int CTRL_CLEAR_BIT = 1;
	localparam int ACC_LSB        = 0;
	localparam int ZF_BIT         = 4;
	localparam int CF_BIT         = 5;
	localparam int BUSY_BIT       = 6;
	localparam int BAD_BIT        = 7;
	localparam int PTR_HIGH_LSB   = 4;
	localparam logic RUN_RESET    = 1'b0;

	typedef enum logic [3:0] {
		OP_NONE, OP_NO_OPERATION, OP_MOVE_TO_MEM, OP_MOVE_TO_WR, OP_PTR_LOW,
		OP_PTR_HIGH, OP_TABLE_READ, OP_OR_MEM, OP_OR_MEM_WB, OP_OR_IMM,
		OP_OR_IMM_WB, OP_ROTATE
	} op_t;

	typedef enum logic [1:0] {
		ST_READY = 2'b00,
		ST_TABLE = 2'b01
	} exec_state_t;

	typedef struct packed {
		op_t              op;
		logic [RAM_AW-1:0] mem_addr;
		logic [WR_AW-1:0]  wr_idx;
		logic [DATA_W-1:0] imm;
	} decoded_t;

	typedef struct packed {
		logic              we;
		logic [RAM_AW-1:0] addr;
		logic [DATA_W-1:0] data;
	} ram_write_t;

	function automatic decoded_t decode(input logic [INSTR_W-1:0] w);
		decoded_t d;
		d.op       = OP_NONE;
		d.mem_addr = w[6:0];
		d.wr_idx   = w[3:0];
		d.imm      = w[7:4];
		if (w == OPC_NO_OPERATION)
			d.op = OP_NO_OPERATION;
		else if (w[15:11] == OPC_MOVE_TO_MEM || w[15:11] == OPC_MOVE_TO_WR) begin
			d.op     = (w[15:11] == OPC_MOVE_TO_MEM) ? OP_MOVE_TO_MEM : OP_MOVE_TO_WR;
			d.wr_idx = w[10:7];
		end else if (w[15:8] == OPC_OR_IMM)
			d.op = OP_OR_IMM;
		else if (w[15:8] == OPC_OR_IMM_WB)
			d.op = OP_OR_IMM_WB;
		else begin
			case (w[15:7])
				OPC_PTR_LOW:    d.op = OP_PTR_LOW;
				OPC_PTR_HIGH:   d.op = OP_PTR_HIGH;
				OPC_TABLE_READ: d.op = OP_TABLE_READ;
				OPC_OR_MEM:     d.op = OP_OR_MEM;
				OPC_OR_MEM_WB:  d.op = OP_OR_MEM_WB;
				OPC_ROTATE:     d.op = OP_ROTATE;
				default:        d.op = OP_NONE;
			endcase
		end
		return d;
	endfunction
endpackage

// ---- data_ram.sv ----
// Nibble-wide data memory, one write port and two read ports
module data_ram
	import move_or_rotate_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire ram_write_t        wr,
	input  wire logic [RAM_AW-1:0] rd_addr_a,
	output logic      [DATA_W-1:0] rd_data_a,
	input  wire logic [RAM_AW-1:0] rd_addr_b,
	output logic      [DATA_W-1:0] rd_data_b
);
	logic [DATA_W-1:0] mem [RAM_DEPTH];

	always_ff @(posedge sys_clk) begin
		if (wr.we)
			mem[wr.addr] <= wr.data;
	end

	assign rd_data_a = mem[rd_addr_a];
	assign rd_data_b = mem[rd_addr_b];
endmodule

// ---- table_rom.sv ----
// Look-up table store, loaded by software, read with one cycle latency
module table_rom
	import move_or_rotate_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              wr_en,
	input  wire logic [ROM_AW-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              rd_en,
	input  wire logic [ROM_AW-1:0] rd_addr,
	output logic      [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] mem [ROM_DEPTH];

	always_ff @(posedge sys_clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	always_ff @(posedge sys_clk) begin
		if (rd_en)
			rd_data <= mem[rd_addr];
	end
endmodule

// ---- move_or_rotate_table_exec.sv ----
// Execute slice for moves, table pointer and table reads, OR forms and rotate left
// Operation
// - Fixed fields: memory address, immediate; register index w[3:0], w[10:7] for moves
// - Register to memory and accumulator, zero flag
// - Memory to register and accumulator, zero flag
// - Memory nibble into low table pointer
// - Memory nibble into high table pointer
// - Two-cycle table read into addressed memory
// - Memory OR accumulator into accumulator only
// - Register OR immediate into accumulator only
// - Memory OR accumulator into memory and accumulator
// - Register OR immediate into register and accumulator
// - Rotate left through carry, memory and accumulator
//
// Our own choices: the placing of the registers and the APB register port.
module move_or_rotate_table_exec
	import move_or_rotate_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [APB_AW-1:0]  paddr,
	input  wire logic [APB_DW-1:0]  pwdata,
	output logic      [APB_DW-1:0]  prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               instr_valid,
	input  wire logic [INSTR_W-1:0] instr_word,
	output logic                    instr_ready,
	output logic                    instr_done,
	output logic      [DATA_W-1:0]  accumulator,
	output logic                    zero_flag,
	output logic                    carry_flag
);
	exec_state_t       state;
	exec_state_t       next_state;
	decoded_t          dec;
	ram_write_t        exec_wr;
	ram_write_t        ram_wr;
	logic              run;
	logic              bad_opcode;
	logic              taken;
	logic [DATA_W-1:0] table_pointer_low;
	logic [DATA_W-1:0] table_pointer_high;
	logic [RAM_AW-1:0] table_dest;
	logic [ROM_AW-1:0] rom_addr;
	logic [RAM_AW-1:0] ram_addr;
	logic [DATA_W-1:0] mem_val;
	logic [DATA_W-1:0] wr_val;
	logic [DATA_W-1:0] rom_data;
	logic [RAM_AW-1:0] port_b_addr;
	logic [DATA_W-1:0] next_acc;
	logic              next_zf;
	logic              next_cf;
	logic              load_low;
	logic              load_high;
	logic              rom_rd;
	logic              done_now;
	logic              bad_now;
	logic              apb_access;
	logic              apb_done;
	logic              apb_wr;
	logic              apb_bad;
	logic [APB_DW-1:0] apb_rdata;
	logic              rom_wr_en;
	logic              ram_apb_we;
	logic              core_we;

	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		return v == '0;
	endfunction

	// Ops whose accumulator result also sets the zero flag
	function automatic logic sets_zero(input op_t op);
		case (op)
			OP_MOVE_TO_MEM, OP_MOVE_TO_WR, OP_OR_MEM, OP_OR_IMM,
			OP_OR_MEM_WB, OP_OR_IMM_WB, OP_ROTATE: sets_zero = 1'b1;
			default:                               sets_zero = 1'b0;
		endcase
	endfunction

	// Halted-only registers would race the executing core
	function automatic logic addr_refused(input logic [APB_AW-1:0] a, input logic w,
			input logic running);
		case (a)
			REG_CTRL, REG_ROM_ADDR, REG_RAM_ADDR: addr_refused = 1'b0;
			REG_STATUS, REG_TABLE_PTR:            addr_refused = w;
			REG_ROM_DATA:                         addr_refused = ~w;
			REG_CORE:                             addr_refused = w & running;
			REG_RAM_DATA:                         addr_refused = running;
			default:                              addr_refused = 1'b1;
		endcase
	endfunction

	assign dec   = decode(instr_word);
	assign taken = instr_valid & instr_ready & (state == ST_READY);

	// Port B serves the working register while running, software otherwise
	assign port_b_addr = run ? RAM_AW'(dec.wr_idx) : ram_addr;

	data_ram u_ram (
		.sys_clk   (sys_clk),
		.wr        (ram_wr),
		.rd_addr_a (dec.mem_addr),
		.rd_data_a (mem_val),
		.rd_addr_b (port_b_addr),
		.rd_data_b (wr_val)
	);

	table_rom u_rom (
		.sys_clk (sys_clk),
		.wr_en   (rom_wr_en),
		.wr_addr (rom_addr),
		.wr_data (pwdata[DATA_W-1:0]),
		.rd_en   (rom_rd),
		.rd_addr ({table_pointer_high, table_pointer_low}),
		.rd_data (rom_data)
	);

	always_comb begin
		next_state = state;
		next_acc   = accumulator;
		next_zf    = zero_flag;
		next_cf    = carry_flag;
		exec_wr    = '0;
		load_low   = 1'b0;
		load_high  = 1'b0;
		rom_rd     = 1'b0;
		done_now   = 1'b0;
		bad_now    = 1'b0;
		case (state)
			ST_READY: begin
				if (taken) begin
					done_now = 1'b1;
					case (dec.op)
						OP_MOVE_TO_MEM: begin
							next_acc = wr_val;
							exec_wr  = '{we: 1'b1, addr: dec.mem_addr, data: wr_val};
						end
						OP_MOVE_TO_WR: begin
							next_acc = mem_val;
							exec_wr  = '{we: 1'b1, addr: RAM_AW'(dec.wr_idx), data: mem_val};
						end
						OP_PTR_LOW:  load_low  = 1'b1;
						OP_PTR_HIGH: load_high = 1'b1;
						// ROM output is registered; the entry lands next cycle
						OP_TABLE_READ: begin
							rom_rd     = 1'b1;
							done_now   = 1'b0;
							next_state = ST_TABLE;
						end
						OP_OR_MEM: next_acc = mem_val | accumulator;
						OP_OR_IMM: next_acc = wr_val | dec.imm;
						OP_OR_MEM_WB: begin
							next_acc = mem_val | accumulator;
							exec_wr  = '{we: 1'b1, addr: dec.mem_addr, data: next_acc};
						end
						OP_OR_IMM_WB: begin
							next_acc = wr_val | dec.imm;
							exec_wr  = '{we: 1'b1, addr: RAM_AW'(dec.wr_idx), data: next_acc};
						end
						OP_ROTATE: begin
							next_acc = {mem_val[DATA_W-2:0], carry_flag};
							next_cf  = mem_val[DATA_W-1];
							exec_wr  = '{we: 1'b1, addr: dec.mem_addr, data: next_acc};
						end
						OP_NO_OPERATION: ;
						default: bad_now = 1'b1;
					endcase
					if (sets_zero(dec.op))
						next_zf = is_zero(next_acc);
				end
			end
			ST_TABLE: begin
				// Second machine cycle: table data lands in memory
				exec_wr    = '{we: 1'b1, addr: table_dest, data: rom_data};
				done_now   = 1'b1;
				next_state = ST_READY;
			end
			default: next_state = ST_READY;
		endcase
	end

	// Software may touch memory only while the core is halted
	assign ram_wr = exec_wr.we ? exec_wr :
		ram_write_t'{we: ram_apb_we, addr: ram_addr, data: pwdata[DATA_W-1:0]};

	always_ff @(posedge sys_clk) begin
		if (rst)
			state <= ST_READY;
		else
			state <= next_state;
	end

	// Operand word is gone by the second cycle, so keep the destination
	always_ff @(posedge sys_clk) begin
		if (rst)
			table_dest <= '0;
		else if (taken)
			table_dest <= dec.mem_addr;
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			instr_ready <= 1'b0;
		else
			instr_ready <= run & (next_state == ST_READY);
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			instr_done <= 1'b0;
		else
			instr_done <= done_now;
	end

	// Execution wins over a software write in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst)
			accumulator <= '0;
		else if (state == ST_TABLE || taken)
			accumulator <= next_acc;
		else if (core_we)
			accumulator <= pwdata[ACC_LSB +: DATA_W];
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			zero_flag  <= 1'b0;
			carry_flag <= 1'b0;
		end else if (state == ST_TABLE || taken) begin
			zero_flag  <= next_zf;
			carry_flag <= next_cf;
		end else if (core_we) begin
			zero_flag  <= pwdata[ZF_BIT];
			carry_flag <= pwdata[CF_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			table_pointer_low <= '0;
		else if (load_low)
			table_pointer_low <= mem_val;
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			table_pointer_high <= '0;
		else if (load_high)
			table_pointer_high <= mem_val;
	end

	// A new bad opcode beats a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst)
			bad_opcode <= 1'b0;
		else if (bad_now)
			bad_opcode <= 1'b1;
		else if (apb_wr && paddr == REG_CTRL && pwdata[CTRL_CLEAR_BIT])
			bad_opcode <= 1'b0;
	end

	assign apb_access = psel & penable & ~pready;
	assign apb_done   = psel & penable & pready;
	assign apb_wr     = apb_done & pwrite & ~pslverr;
	assign apb_bad    = addr_refused(paddr, pwrite, run);
	assign rom_wr_en  = apb_wr && paddr == REG_ROM_DATA;
	assign ram_apb_we = apb_wr && paddr == REG_RAM_DATA;
	assign core_we    = apb_wr && paddr == REG_CORE;

	always_comb begin
		apb_rdata = '0;
		case (paddr)
			REG_CTRL:      apb_rdata[CTRL_RUN_BIT] = run;
			REG_STATUS: begin
				apb_rdata[ACC_LSB +: DATA_W] = accumulator;
				apb_rdata[ZF_BIT]            = zero_flag;
				apb_rdata[CF_BIT]            = carry_flag;
				apb_rdata[BUSY_BIT]          = state != ST_READY;
				apb_rdata[BAD_BIT]           = bad_opcode;
			end
			REG_CORE: begin
				apb_rdata[ACC_LSB +: DATA_W] = accumulator;
				apb_rdata[ZF_BIT]            = zero_flag;
				apb_rdata[CF_BIT]            = carry_flag;
			end
			REG_TABLE_PTR: begin
				apb_rdata[0 +: DATA_W]            = table_pointer_low;
				apb_rdata[PTR_HIGH_LSB +: DATA_W] = table_pointer_high;
			end
			REG_ROM_ADDR:  apb_rdata[ROM_AW-1:0] = rom_addr;
			REG_RAM_ADDR:  apb_rdata[RAM_AW-1:0] = ram_addr;
			REG_RAM_DATA:  apb_rdata[DATA_W-1:0] = wr_val;
			default:       apb_rdata = '0;
		endcase
	end

	// One wait state: answer registered in the first access cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= apb_access;
			pslverr <= apb_access & apb_bad;
		end
	end

	// Zero for writes and refusals so stale data never leaks
	always_ff @(posedge sys_clk) begin
		if (rst)
			prdata <= '0;
		else if (apb_access && !pwrite && !apb_bad)
			prdata <= apb_rdata;
		else if (apb_access)
			prdata <= '0;
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			run <= RUN_RESET;
		else if (apb_wr && paddr == REG_CTRL)
			run <= pwdata[CTRL_RUN_BIT];
	end

	// Address steps after each store so a table loads as a stream
	always_ff @(posedge sys_clk) begin
		if (rst)
			rom_addr <= '0;
		else if (apb_wr && paddr == REG_ROM_ADDR)
			rom_addr <= pwdata[ROM_AW-1:0];
		else if (rom_wr_en)
			rom_addr <= rom_addr + ROM_AW'(1);
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			ram_addr <= '0;
		else if (apb_wr && paddr == REG_RAM_ADDR)
			ram_addr <= pwdata[RAM_AW-1:0];
	end
endmodule

// ---- move_or_rotate_monitor.sv ----
// Port checker for the move, OR, rotate and table execute slice
module move_or_rotate_monitor
	import move_or_rotate_pkg::*;
(
	input wire logic               sys_clk,
	input wire logic               rst,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               instr_valid,
	input wire logic [INSTR_W-1:0] instr_word,
	input wire logic               instr_ready,
	input wire logic               instr_done,
	input wire logic [DATA_W-1:0]  accumulator,
	input wire logic               zero_flag,
	input wire logic               carry_flag
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic       take;
	logic       zop;
	logic       keep;
	logic [8:0] op9;
	assign take = instr_valid && instr_ready;
	assign op9  = instr_word[15:7];
	assign zop  = take && (instr_word[15:11] == OPC_MOVE_TO_MEM
		|| instr_word[15:11] == OPC_MOVE_TO_WR || op9 == OPC_OR_MEM
		|| op9 == OPC_OR_MEM_WB || op9 == OPC_ROTATE
		|| instr_word[15:8] == OPC_OR_IMM || instr_word[15:8] == OPC_OR_IMM_WB);
	assign keep = take && (op9 == OPC_PTR_LOW || op9 == OPC_PTR_HIGH
		|| instr_word == OPC_NO_OPERATION);
	sequence s_access;
		psel && penable && !pready ##1 pready;
	endsequence
	sequence s_table_take;
		take && op9 == OPC_TABLE_READ;
	endsequence
	sequence s_or_take;
		take && (op9 == OPC_OR_MEM || op9 == OPC_OR_MEM_WB);
	endsequence
	a_apb_one_wait: assert property (psel && !penable |=> s_access)
		else $error("apb answer not after one wait state");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_done_bound: assert property (take |-> ##[1:2] instr_done)
		else $error("instruction did not complete");
	a_table_stall: assert property (s_table_take
		|=> !instr_ready && !instr_done ##1 instr_done)
		else $error("table read not two cycles");
	a_zero_follow: assert property (zop |=> zero_flag == (accumulator == 4'h0))
		else $error("zero flag does not match accumulator");
	a_state_keep: assert property (keep
		|=> $stable(accumulator) && $stable({zero_flag, carry_flag}))
		else $error("state changed by pointer load or no-op");
	a_rotate_in: assert property (take && op9 == OPC_ROTATE
		|=> accumulator[0] == $past(carry_flag))
		else $error("old carry not rotated into bit 0");
	a_or_keeps_bits: assert property (s_or_take
		|=> (accumulator & $past(accumulator)) == $past(accumulator))
		else $error("or lost accumulator bits");
endmodule

// ---- tb_move_or_rotate_table_exec.sv ----
// Self-checking bench for the execute slice over APB and the instruction port
module tb_move_or_rotate_table_exec
	import move_or_rotate_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [APB_AW-1:0] paddr = '0;
	logic [APB_DW-1:0] pwdata = '0, prdata, q;
	logic instr_valid = 0, instr_ready, instr_done, zero_flag, carry_flag, e;
	logic [INSTR_W-1:0] instr_word = '0;
	logic [DATA_W-1:0] accumulator;
	int bad_count = 0, n_tests = 0;
	logic [6:0] ra[7] = '{7'h20, 7'h21, 7'h03, 7'h02, 7'h22, 7'h23, 7'h01};
	logic [3:0] rv[7] = '{4'h5, 4'h0, 4'hA, 4'h0, 4'h3, 4'h2, 4'h6};
	logic [6:0] fa[7] = '{7'h20, 7'h01, 7'h21, 7'h24, 7'h25, 7'h03, 7'h02};
	logic [3:0] fv[7] = '{4'hB, 4'hB, 4'hC, 4'hA, 4'h9, 4'hF, 4'h0};
	always #25 sys_clk = ~sys_clk;
	move_or_rotate_table_exec i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready), .instr_done(instr_done),
		.accumulator(accumulator), .zero_flag(zero_flag), .carry_flag(carry_flag));
	task check(input logic [APB_DW-1:0] got, input logic [APB_DW-1:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d, input logic ee);
		apb(1, a, d);
		check(e, ee);
	endtask
	task rd(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] x, input logic ee);
		apb(0, a, 0);
		check({e, q}, {ee, x});
	endtask
	task step(input logic [15:0] w, input logic [3:0] a, input logic z, c, input int cyc);
		int n;
		@(posedge sys_clk);
		instr_valid <= 1;
		instr_word <= w;
		do @(posedge sys_clk); while (instr_ready !== 1'b1);
		instr_valid <= 0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (instr_done !== 1'b1 && n < 9);
		#1;
		check({accumulator, zero_flag, carry_flag, 8'(n)}, {a, z, c, 8'(cyc)});
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 0;
		rd(REG_STATUS, 0, 0);
		rd(REG_CORE, 0, 0);
		rd(REG_CTRL, 32'(RUN_RESET), 0);
		check(instr_ready, 0);
		$display("test reset done");
		for (int i = 0; i < 7; i++) begin
			wr(REG_RAM_ADDR, 32'(ra[i]), 0);
			wr(REG_RAM_DATA, 32'(rv[i]), 0);
		end
		wr(REG_ROM_ADDR, 32'h23, 0);
		wr(REG_ROM_DATA, 32'h9, 0);
		wr(REG_CORE, 32'h28, 0);
		wr(REG_CTRL, 32'h1, 0);
		step({9'h074, 7'h21}, 4'h8, 0, 1, 1);
		step({9'h14C, 7'h20}, 4'hB, 0, 0, 1);
		step({5'h0D, 4'h1, 7'h20}, 4'hB, 0, 0, 1);
		step({8'h3E, 4'h4, 4'h3}, 4'hE, 0, 0, 1);
		step({9'h076, 7'h21}, 4'hE, 0, 0, 1);
		step({5'h0F, 4'h3, 7'h24}, 4'hA, 0, 0, 1);
		step({9'h130, 7'h22}, 4'hA, 0, 0, 1);
		step({9'h131, 7'h23}, 4'hA, 0, 0, 1);
		step({9'h132, 7'h25}, 4'hA, 0, 0, 2);
		step(16'h0000, 4'hA, 0, 0, 1);
		step({5'h0D, 4'h2, 7'h02}, 4'h0, 1, 0, 1);
		step({9'h14C, 7'h21}, 4'hC, 0, 1, 1);
		step({8'h3F, 4'h5, 4'h3}, 4'hF, 0, 1, 1);
		step(16'hFFFF, 4'hF, 0, 1, 1);
		$display("test execute done");
		wr(REG_CORE, 32'h0, 1);
		rd(REG_RAM_DATA, 0, 1);
		wr(REG_CTRL, 32'h0, 0);
		rd(REG_STATUS, 32'hAF, 0);
		rd(REG_TABLE_PTR, 32'h23, 0);
		for (int i = 0; i < 7; i++) begin
			wr(REG_RAM_ADDR, 32'(fa[i]), 0);
			rd(REG_RAM_DATA, 32'(fv[i]), 0);
		end
		rd(REG_RAM_DATA - 8'h1C + 8'h40, 0, 1);
		rd(REG_ROM_DATA, 0, 1);
		wr(REG_STATUS, 32'h0, 1);
		wr(REG_CTRL, 32'h2, 0);
		rd(REG_STATUS, 32'h2F, 0);
		rd(REG_CORE, 32'h2F, 0);
		$display("test registers done");
		complete_run();
	end
endmodule
bind move_or_rotate_table_exec move_or_rotate_monitor i_mon (.sys_clk(sys_clk), .rst(rst),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
	.instr_done(instr_done), .accumulator(accumulator), .zero_flag(zero_flag),
	.carry_flag(carry_flag));
